//--- inc/cnaf_pkg.sv
// package: register map, reset values, types for the acceptance filter
package cnaf_pkg;
  localparam int NUM_FILT    = 16;
  localparam int NUM_MASK    = 2;
  localparam int LEGACY_FILT = 6;
  localparam int ADR_W       = 9;
  localparam int DATA_BITS   = 18;

  // register indices, byte address is index * 4
  localparam logic [6:0] IDX_MASK_BASE = 7'h40;
  localparam logic [6:0] IDX_EN_LO     = 7'h48;
  localparam logic [6:0] IDX_EN_HI     = 7'h49;
  localparam logic [6:0] IDX_COUNT     = 7'h4a;
  localparam logic [6:0] IDX_PTR_BASE  = 7'h4b;
  localparam logic [6:0] IDX_PTR_LAST  = 7'h52;
  localparam logic [6:0] IDX_MSEL_BASE = 7'h53;
  localparam logic [6:0] IDX_MSEL_LAST = 7'h56;
  localparam logic [6:0] IDX_CTRL      = 7'h57;
  localparam logic [6:0] IDX_STAT      = 7'h58;

  // byte lanes inside one filter or mask group
  localparam logic [1:0] BYTE_ID_HI  = 2'h0;
  localparam logic [1:0] BYTE_ID_LO  = 2'h1;
  localparam logic [1:0] BYTE_EXT_HI = 2'h2;
  localparam logic [1:0] BYTE_EXT_LO = 2'h3;

  // low identifier byte layout
  localparam int         LO_EXT_BIT  = 3;
  localparam logic [7:0] LO_KEEP     = 8'heb;
  localparam logic [7:0] LO_KEEP_LEG = 8'he3;
  localparam int         CTRL_CFG_BIT = 7;

  // reset values, compare count cap and last valid pointer code
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_EN_LO  = 8'h3f;
  localparam logic [7:0]  RST_EN_HI  = 8'h10;
  localparam logic [63:0] RST_PTR    = 64'h0000_0000_0011_1100;
  localparam logic [31:0] RST_MSEL   = 32'h0000_0550;
  localparam logic [4:0]  RST_COUNT  = 5'h00;
  localparam logic [4:0]  COUNT_MAX  = 5'h12;
  localparam logic [3:0]  PTR_LAST_OK = 4'h7;

  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00,
    MODE_ENH    = 2'b01,
    MODE_FIFO   = 2'b10,
    MODE_RSVD   = 2'b11
  } cnaf_mode_t;

  typedef enum logic [1:0] {
    CHOICE_MASK0 = 2'b00,
    CHOICE_MASK1 = 2'b01,
    CHOICE_F15   = 2'b10,
    CHOICE_NONE  = 2'b11
  } cnaf_choice_t;

  // standard identifiers sit in ident[28:18]; data byte 0 in data[23:16]
  typedef struct packed {
    logic        valid;
    logic        ext;
    logic [28:0] ident;
    logic [3:0]  lengthCode;
    logic [23:0] data;
  } cnaf_rx_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] filter;
    logic [3:0] dest;
  } cnaf_acc_t;
endpackage

//--- logic/cnaf_filter.sv
// acceptance filter: sixteen filters, two masks, wishbone register slave
`timescale 1ns/100ps
module cnaf_filter
  import cnaf_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire cnaf_rx_t         rxMsg,
  output cnaf_acc_t             accOut
);

  logic [7:0]   fHi_ff  [NUM_FILT];
  logic [7:0]   fLo_ff  [NUM_FILT];
  logic [7:0]   fEh_ff  [NUM_FILT];
  logic [7:0]   fEl_ff  [NUM_FILT];
  logic [7:0]   mHi_ff  [NUM_MASK];
  logic [7:0]   mLo_ff  [NUM_MASK];
  logic [7:0]   mEh_ff  [NUM_MASK];
  logic [7:0]   mEl_ff  [NUM_MASK];
  logic [3:0]   ptr_ff  [NUM_FILT];
  logic [1:0]   mSel_ff [NUM_FILT];
  logic [15:0]  en_ff;
  logic [4:0]   count_ff;
  cnaf_mode_t   mode_ff;
  logic         cfg_ff;
  logic         ack_ff;
  logic [7:0]   dat_ff;
  cnaf_acc_t    acc_ff;
  logic [7:0]   stat_ff;

  logic [6:0]   idx;
  logic         reqOn;
  logic         wrEn;
  logic         legacy;
  logic [7:0]   nxt_dat;
  logic [4:0]   nBits;
  logic [15:0]  hit;
  logic [15:0]  active;
  logic         anyHit;
  logic [3:0]   winIdx;
  logic [3:0]   ptrIdx;
  logic [1:0]   mselIdx;
  logic [28:0]  f15Id;
  logic [3:0]   winPtr;

  assign idx     = wb_adr_i[ADR_W-1:2];
  assign reqOn   = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the master samples ack
  assign wrEn    = reqOn && wb_we_i && ack_ff && wb_sel_i[0];
  assign legacy  = (mode_ff == MODE_LEGACY);
  assign ptrIdx  = 4'(idx - IDX_PTR_BASE);
  assign mselIdx = 2'(idx - IDX_MSEL_BASE);

  function automatic logic filtPresent(input logic [3:0] f, input logic leg);
    filtPresent = !leg || (f < 4'(LEGACY_FILT));
  endfunction

  // bus handshake, one wait state then ack for exactly one cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= reqOn && !ack_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dat_ff <= RST_BYTE;
    end else if (reqOn && !ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = {24'h000000, dat_ff};

  // read mux; unmapped and absent registers read zero
  always_comb begin
    nxt_dat = RST_BYTE;
    if (idx < IDX_MASK_BASE) begin
      if (filtPresent(idx[5:2], legacy)) begin
        case (idx[1:0])
          BYTE_ID_HI:  nxt_dat = fHi_ff[idx[5:2]];
          BYTE_ID_LO:  nxt_dat = fLo_ff[idx[5:2]] & LO_KEEP;
          BYTE_EXT_HI: nxt_dat = fEh_ff[idx[5:2]];
          default:     nxt_dat = fEl_ff[idx[5:2]];
        endcase
      end
    end else if (idx < IDX_EN_LO) begin
      case (idx[1:0])
        BYTE_ID_HI:  nxt_dat = mHi_ff[idx[2]];
        BYTE_ID_LO:  nxt_dat = mLo_ff[idx[2]] & (legacy ? LO_KEEP_LEG : LO_KEEP);
        BYTE_EXT_HI: nxt_dat = mEh_ff[idx[2]];
        default:     nxt_dat = mEl_ff[idx[2]];
      endcase
    end else if (idx == IDX_EN_LO) begin
      nxt_dat = legacy ? RST_BYTE : en_ff[7:0];
    end else if (idx == IDX_EN_HI) begin
      nxt_dat = legacy ? RST_BYTE : en_ff[15:8];
    end else if (idx == IDX_COUNT) begin
      nxt_dat = {3'b000, count_ff};
    end else if (idx <= IDX_PTR_LAST) begin
      nxt_dat = {ptr_ff[{ptrIdx[2:0], 1'b1}], ptr_ff[{ptrIdx[2:0], 1'b0}]};
    end else if (idx <= IDX_MSEL_LAST) begin
      nxt_dat = {mSel_ff[{mselIdx, 2'd3}], mSel_ff[{mselIdx, 2'd2}],
                 mSel_ff[{mselIdx, 2'd1}], mSel_ff[{mselIdx, 2'd0}]};
    end else if (idx == IDX_CTRL) begin
      nxt_dat = {cfg_ff, 5'b00000, mode_ff};
    end else if (idx == IDX_STAT) begin
      nxt_dat = stat_ff;
    end
  end

  // filter identifier bytes; absent filters ignore writes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_FILT; i++) begin
        fHi_ff[i] <= RST_BYTE;
        fLo_ff[i] <= RST_BYTE;
        fEh_ff[i] <= RST_BYTE;
        fEl_ff[i] <= RST_BYTE;
      end
    end else if (wrEn && idx < IDX_MASK_BASE && filtPresent(idx[5:2], legacy)) begin
      case (idx[1:0])
        BYTE_ID_HI:  fHi_ff[idx[5:2]] <= wb_dat_i[7:0];
        BYTE_ID_LO:  fLo_ff[idx[5:2]] <= wb_dat_i[7:0] & LO_KEEP;
        BYTE_EXT_HI: fEh_ff[idx[5:2]] <= wb_dat_i[7:0];
        default:     fEl_ff[idx[5:2]] <= wb_dat_i[7:0];
      endcase
    end
  end

  // mask bytes; frame bit is cleared and locked while legacy
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_MASK; i++) begin
        mHi_ff[i] <= RST_BYTE;
        mLo_ff[i] <= RST_BYTE;
        mEh_ff[i] <= RST_BYTE;
        mEl_ff[i] <= RST_BYTE;
      end
    end else begin
      if (wrEn && idx >= IDX_MASK_BASE && idx < IDX_EN_LO) begin
        case (idx[1:0])
          BYTE_ID_HI:  mHi_ff[idx[2]] <= wb_dat_i[7:0];
          BYTE_ID_LO:  mLo_ff[idx[2]] <= wb_dat_i[7:0] & LO_KEEP;
          BYTE_EXT_HI: mEh_ff[idx[2]] <= wb_dat_i[7:0];
          default:     mEl_ff[idx[2]] <= wb_dat_i[7:0];
        endcase
      end
      if (legacy) begin
        for (int i = 0; i < NUM_MASK; i++) begin
          mLo_ff[i][LO_EXT_BIT] <= 1'b0;
        end
      end
    end
  end

  // enable bits only reachable outside legacy
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      en_ff <= {RST_EN_HI, RST_EN_LO};
    end else if (wrEn && !legacy) begin
      if (idx == IDX_EN_LO) begin
        en_ff[7:0] <= wb_dat_i[7:0];
      end else if (idx == IDX_EN_HI) begin
        en_ff[15:8] <= wb_dat_i[7:0];
      end
    end
  end

  // configuration-only registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_ff <= RST_COUNT;
    end else if (legacy) begin
      count_ff <= RST_COUNT;
    end else if (wrEn && cfg_ff && idx == IDX_COUNT) begin
      count_ff <= wb_dat_i[4:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_FILT; i++) begin
        ptr_ff[i]  <= RST_PTR[i*4 +: 4];
        mSel_ff[i] <= RST_MSEL[i*2 +: 2];
      end
    end else if (wrEn && cfg_ff) begin
      if (idx >= IDX_PTR_BASE && idx <= IDX_PTR_LAST) begin
        ptr_ff[{ptrIdx[2:0], 1'b0}] <= wb_dat_i[3:0];
        ptr_ff[{ptrIdx[2:0], 1'b1}] <= wb_dat_i[7:4];
      end else if (idx >= IDX_MSEL_BASE && idx <= IDX_MSEL_LAST) begin
        for (int k = 0; k < 4; k++) begin
          mSel_ff[{mselIdx, 2'(k)}] <= wb_dat_i[k*2 +: 2];
        end
      end
    end
  end

  // mode and configuration control; start in configuration, legacy
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_ff <= MODE_LEGACY;
      cfg_ff  <= 1'b1;
    end else if (wrEn && idx == IDX_CTRL) begin
      mode_ff <= cnaf_mode_t'(wb_dat_i[1:0]);
      cfg_ff  <= wb_dat_i[CTRL_CFG_BIT];
    end
  end

  // number of data bits compared for standard frames
  always_comb begin
    case (rxMsg.lengthCode)
      4'h0:    nBits = 5'h00;
      4'h1:    nBits = {2'b00, count_ff[2:0]};
      4'h2:    nBits = {1'b0, count_ff[3:0]};
      default: nBits = (count_ff > COUNT_MAX) ? COUNT_MAX : count_ff;
    endcase
  end

  assign f15Id = {fHi_ff[15], fLo_ff[15][7:5], fLo_ff[15][1:0], fEh_ff[15], fEl_ff[15]};

  for (genvar g = 0; g < NUM_FILT; g++) begin : gFilt
    logic [28:0] fId;
    logic [28:0] mId;
    logic        mExt;
    logic        dataOk;
    logic        idOk;
    logic        typeOk;

    assign fId = {fHi_ff[g], fLo_ff[g][7:5], fLo_ff[g][1:0], fEh_ff[g], fEl_ff[g]};

    always_comb begin
      case (cnaf_choice_t'(mSel_ff[g]))
        CHOICE_MASK0: begin
          mId  = {mHi_ff[0], mLo_ff[0][7:5], mLo_ff[0][1:0], mEh_ff[0], mEl_ff[0]};
          mExt = mLo_ff[0][LO_EXT_BIT];
        end
        CHOICE_MASK1: begin
          mId  = {mHi_ff[1], mLo_ff[1][7:5], mLo_ff[1][1:0], mEh_ff[1], mEl_ff[1]};
          mExt = mLo_ff[1][LO_EXT_BIT];
        end
        CHOICE_F15: begin
          mId  = f15Id;
          mExt = fLo_ff[15][LO_EXT_BIT];
        end
        default: begin
          mId  = '1;
          mExt = 1'b1;
        end
      endcase
    end

    // data bits ride on the extended bit positions of a standard filter
    always_comb begin
      dataOk = 1'b1;
      for (int j = 0; j < DATA_BITS; j++) begin
        if (5'(j) < nBits && mId[17-j] && (rxMsg.data[23-j] != fId[17-j])) begin
          dataOk = 1'b0;
        end
      end
    end

    assign idOk = rxMsg.ext ? (((rxMsg.ident ^ fId) & mId) == 29'h0)
                : ((((rxMsg.ident[28:18] ^ fId[28:18]) & mId[28:18]) == 11'h0) && dataOk);
    // legacy always enforces the frame type held by the filter
    assign typeOk = !(legacy || mExt) || (fLo_ff[g][LO_EXT_BIT] == rxMsg.ext);
    assign active[g] = filtPresent(4'(g), legacy) && (legacy || en_ff[g]);
    // reserved pointer codes keep a filter from delivering anywhere
    assign hit[g] = active[g] && (ptr_ff[g] <= PTR_LAST_OK) && idOk && typeOk;
  end

  // lowest numbered matching filter wins
  always_comb begin
    winIdx = 4'h0;
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        winIdx = 4'(i);
      end
    end
  end

  assign anyHit = |hit;
  assign winPtr = ptr_ff[winIdx];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      acc_ff <= '0;
    end else begin
      acc_ff.valid  <= rxMsg.valid && anyHit;
      acc_ff.filter <= winIdx;
      acc_ff.dest   <= ptr_ff[winIdx];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stat_ff <= RST_BYTE;
    end else if (rxMsg.valid && anyHit) begin
      stat_ff <= {ptr_ff[winIdx], winIdx};
    end
  end

  assign accOut = acc_ff;

  a_lo_reserved:
  assert property (@(posedge mclk) disable iff (!reset_n)
    (wb_ack_o && !wb_we_i && wb_adr_i[ADR_W-1:2] < IDX_MASK_BASE && wb_adr_i[3:2] == BYTE_ID_LO)
      |-> (wb_dat_o[4] == 1'b0 && wb_dat_o[2] == 1'b0))
    else $error("filter low byte reserved bits not zero");

  a_legacy_absent:
  assert property (@(posedge mclk) disable iff (!reset_n)
    ($stable(mode_ff) && legacy && wb_ack_o && !wb_we_i && wb_adr_i[ADR_W-1:2] < IDX_MASK_BASE
      && wb_adr_i[7:4] >= 4'h6) |-> (wb_dat_o == 32'h0))
    else $error("absent filter read nonzero in legacy");

  a_enable_hidden:
  assert property (@(posedge mclk) disable iff (!reset_n)
    ($past(legacy) && wb_ack_o && !wb_we_i
      && (wb_adr_i[ADR_W-1:2] == IDX_EN_LO || wb_adr_i[ADR_W-1:2] == IDX_EN_HI))
      |-> (wb_dat_o == 32'h0))
    else $error("enable register visible in legacy");

  a_mask_frame_leg:
  assert property (@(posedge mclk) disable iff (!reset_n)
    legacy [*2] |-> (mLo_ff[0][LO_EXT_BIT] == 1'b0 && mLo_ff[1][LO_EXT_BIT] == 1'b0))
    else $error("mask frame bit set in legacy");

  a_count_held:
  assert property (@(posedge mclk) disable iff (!reset_n)
    legacy |=> (count_ff == RST_COUNT))
    else $error("count not held at zero in legacy");

  a_config_lock:
  assert property (@(posedge mclk) disable iff (!reset_n)
    (wrEn && !cfg_ff && idx >= IDX_PTR_BASE && idx <= IDX_PTR_LAST)
      |=> (ptr_ff[0] == $past(ptr_ff[0]) && ptr_ff[15] == $past(ptr_ff[15])))
    else $error("pointer written outside configuration");

  a_length_one:
  assert property (@(posedge mclk) disable iff (!reset_n)
    (rxMsg.lengthCode == 4'h1) |-> (nBits <= 5'h07 && nBits == {2'b00, count_ff[2:0]}))
    else $error("length one compare count wrong");

  a_length_cap:
  assert property (@(posedge mclk) disable iff (!reset_n)
    (rxMsg.lengthCode >= 4'h3) |-> (nBits <= COUNT_MAX))
    else $error("compare count above eighteen");

  a_accept_dest:
  assert property (@(posedge mclk) disable iff (!reset_n)
    (rxMsg.valid && anyHit) |=> (accOut.valid && accOut.dest == $past(winPtr)
      && accOut.filter == $past(winIdx)
      && (($past(hit) >> accOut.filter) & 16'h0001) == 16'h0001
      && ($past(hit) & ((16'h0001 << accOut.filter) - 16'h0001)) == 16'h0000))
    else $error("accepted message lost or misrouted");

  a_disabled_quiet:
  assert property (@(posedge mclk) disable iff (!reset_n)
    (rxMsg.valid && !anyHit) |=> !accOut.valid)
    else $error("acceptance without any active match");

endmodule

//--- tb/can_rx_acceptance_filter_tb_top.sv
// self-checking bench for the acceptance filter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module can_rx_acceptance_filter_tb_top;
  import cnaf_pkg::*;
  logic             mclk;
  logic             reset_n;
  logic             cyc;
  logic             stb;
  logic             we;
  logic             go;
  logic             ack;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [3:0]       gap;
  logic [31:0]      wdat;
  logic [31:0]      rdat;
  logic [7:0]       rd;
  cnaf_rx_t         req;
  cnaf_rx_t         rxMsg;
  cnaf_acc_t        accOut;
  int               nMismatch;
  int               nCompared;

  cnaf_filter cnaf_filter_i (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rxMsg(rxMsg), .accOut(accOut));
  cnaf_rx_model cnaf_rx_model_i (.mclk(mclk), .reset_n(reset_n), .go(go), .req(req),
    .gap(gap), .rxMsg(rxMsg));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic wbAcc(input logic [6:0] i, input logic w, input logic [7:0] d);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'hf;
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      nMismatch++;
      $display("CHECK FAILED bus ack expected 1 seen %b", ack);
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    wbAcc(i, 1'b1, d);
  endtask

  task automatic rdChk(input logic [6:0] i, input logic [7:0] e);
    wbAcc(i, 1'b0, 8'h00);
    `CHK($sformatf("reg %h", i), e, rd)
  endtask

  // one message through the model, prompt and slow in turn
  task automatic rx(input logic x, input logic [28:0] id, input logic [3:0] lc,
                    input logic [23:0] d, input logic acc, input logic [3:0] f,
                    input logic [3:0] dst);
    int k;
    @(posedge mclk);
    go <= 1'b1;
    req <= '{1'b1, x, id, lc, d};
    gap <= gap ^ 4'h3;
    @(posedge mclk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (rxMsg.valid !== 1'b1 && k < 20);
    if (k >= 20) begin
      nMismatch++;
      $display("CHECK FAILED rx valid expected 1 seen %b", rxMsg.valid);
    end
    @(posedge mclk);
    `CHK("accept", acc, accOut.valid)
    if (acc) begin
      `CHK("filter", f, accOut.filter)
      `CHK("dest", dst, accOut.dest)
    end
  endtask

  function automatic int nbits(logic [4:0] c, int l);
    if (l == 0) return 0;
    if (l == 1) return int'(c[2:0]);
    if (l == 2) return int'(c[3:0]);
    return (c > COUNT_MAX) ? int'(COUNT_MAX) : int'(c);
  endfunction

  task automatic tLegacy;
    rdChk(IDX_CTRL, 8'h80);
    rdChk(IDX_EN_LO, 8'h00);
    rdChk(IDX_PTR_BASE + 7'h1, 8'h11);
    rdChk(IDX_MSEL_BASE, 8'h50);
    wr(7'h01, 8'hff);
    rdChk(7'h01, 8'heb);
    wr(7'h02, 8'hff);
    rdChk(7'h02, 8'hff);
    wr(IDX_MASK_BASE + 7'h1, 8'hff);
    rdChk(IDX_MASK_BASE + 7'h1, 8'he3);
    wr(7'h18, 8'hff);
    rdChk(7'h18, 8'h00);
    wr(7'h7f, 8'hff);
    rdChk(7'h7f, 8'h00);
    wr(IDX_COUNT, 8'h1f);
    rdChk(IDX_COUNT, 8'h00);
    wr(IDX_MASK_BASE + 7'h1, 8'h00);
    wr(7'h01, 8'h08);
    rx(1'b1, 29'h0, 4'h0, 24'h0, 1'b1, 4'h0, 4'h0);
    rx(1'b0, 29'h0, 4'h0, 24'h0, 1'b1, 4'h1, 4'h0);
  endtask

  task automatic tEnhanced;
    wr(IDX_CTRL, 8'h81);
    rdChk(IDX_EN_LO, 8'h3f);
    rdChk(IDX_EN_HI, 8'h10);
    wr(7'h18, 8'hff);
    rdChk(7'h18, 8'hff);
    wr(IDX_MASK_BASE + 7'h1, 8'hff);
    rdChk(IDX_MASK_BASE + 7'h1, 8'heb);
    wr(IDX_COUNT, 8'hff);
    rdChk(IDX_COUNT, 8'h1f);
  endtask

  // configuration off: these writes must bounce
  task automatic tCfgLock;
    wr(IDX_CTRL, 8'h02);
    wr(IDX_COUNT, 8'h00);
    rdChk(IDX_COUNT, 8'h1f);
    wr(IDX_PTR_BASE, 8'h77);
    rdChk(IDX_PTR_BASE, 8'h00);
    wr(IDX_MSEL_BASE, 8'h0f);
    rdChk(IDX_MSEL_BASE, 8'h50);
    wr(IDX_CTRL, 8'h81);
  endtask

  task automatic tIdMatch;
    wr(IDX_EN_LO, 8'h01);
    wr(IDX_EN_HI, 8'h00);
    wr(IDX_COUNT, 8'h00);
    wr(7'h00, 8'ha5);
    wr(7'h01, 8'ha0);
    wr(7'h02, 8'h00);
    wr(7'h03, 8'h00);
    wr(IDX_MASK_BASE, 8'hff);
    wr(IDX_MASK_BASE + 7'h1, 8'he0);
    wr(IDX_MASK_BASE + 7'h2, 8'h00);
    wr(IDX_MASK_BASE + 7'h3, 8'h00);
    rx(1'b0, {11'h52d, 18'h0}, 4'h0, 24'h0, 1'b1, 4'h0, 4'h0);
    rx(1'b0, {11'h52c, 18'h0}, 4'h0, 24'h0, 1'b0, 4'h0, 4'h0);
    rx(1'b1, {11'h52d, 18'h3ffff}, 4'h0, 24'h0, 1'b1, 4'h0, 4'h0);
    wr(IDX_MASK_BASE + 7'h1, 8'he8);
    rx(1'b1, {11'h52d, 18'h0}, 4'h0, 24'h0, 1'b0, 4'h0, 4'h0);
    rx(1'b0, {11'h52d, 18'h0}, 4'h0, 24'h0, 1'b1, 4'h0, 4'h0);
    wr(7'h01, 8'ha8);
    rx(1'b1, {11'h52d, 18'h0}, 4'h0, 24'h0, 1'b1, 4'h0, 4'h0);
    rx(1'b0, {11'h52d, 18'h0}, 4'h0, 24'h0, 1'b0, 4'h0, 4'h0);
    wr(7'h01, 8'ha0);
    wr(IDX_MASK_BASE + 7'h1, 8'he0);
    wr(IDX_EN_LO, 8'h00);
    rx(1'b0, {11'h52d, 18'h0}, 4'h0, 24'h0, 1'b0, 4'h0, 4'h0);
    wr(IDX_EN_HI, 8'h80);
    rx(1'b0, 29'h0, 4'h0, 24'h0, 1'b1, 4'hf, 4'h0);
    wr(IDX_EN_HI, 8'h00);
    wr(IDX_EN_LO, 8'h01);
  endtask

  // mismatch in the last id bit: only a mask that ignores it lets it in
  task automatic tChoice;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MSEL_BASE, {6'h0, 2'(c)});
      rx(1'b0, {11'h52c, 18'h0}, 4'h0, 24'h0, c == 1 || c == 2, 4'h0, 4'h0);
    end
    wr(IDX_MSEL_BASE, 8'h50);
  endtask

  task automatic tPointer;
    for (int c = 0; c < 9; c++) begin
      wr(IDX_PTR_BASE, {4'h0, 4'(c)});
      rx(1'b0, {11'h52d, 18'h0}, 4'h0, 24'h0, c <= 7, 4'h0, 4'(c));
    end
    rdChk(IDX_STAT, 8'h70);
    wr(IDX_PTR_BASE, 8'h00);
  endtask

  // a single set data bit at p fails only when p lies inside the compared span
  task automatic tDataCount;
    logic [4:0] cs [10] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h0a, 5'h0a,
                            5'h1f, 5'h12};
    int         lc [10] = '{1, 1, 2, 2, 3, 3, 1, 1, 0, 8};
    int         p [10] = '{6, 7, 14, 15, 17, 18, 1, 2, 0, 17};
    wr(IDX_MASK_BASE, 8'h00);
    wr(IDX_MASK_BASE + 7'h1, 8'h03);
    wr(IDX_MASK_BASE + 7'h2, 8'hff);
    wr(IDX_MASK_BASE + 7'h3, 8'hff);
    for (int i = 0; i < 10; i++) begin
      wr(IDX_COUNT, {3'h0, cs[i]});
      rx(1'b0, {11'h52d, 18'h0}, 4'(lc[i]), 24'h800000 >> p[i],
         p[i] >= nbits(cs[i], lc[i]), 4'h0, 4'h0);
    end
  endtask

  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    nMismatch++;
    printVerdict();
  end

  initial begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h0;
    go = 1'b0;
    req = '0;
    gap = 4'h0;
    nMismatch = 0;
    nCompared = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    tLegacy();
    tEnhanced();
    tCfgLock();
    tIdMatch();
    tChoice();
    tPointer();
    tDataCount();
    printVerdict();
  end
endmodule

//--- tb/cnaf_rx_model.sv
// partner model: receive path handing decoded messages to the filter
`timescale 1ns/100ps
module cnaf_rx_model
  import cnaf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       go,
  input  wire cnaf_rx_t   req,
  input  wire logic [3:0] gap,
  output cnaf_rx_t        rxMsg
);
  cnaf_rx_t   held;
  logic       pend;
  logic [3:0] cnt;

  // idle fields toggle, so a stale message never looks valid
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rxMsg <= '0;
      pend <= 1'b0;
      cnt <= 4'h0;
    end else begin
      rxMsg <= ~rxMsg;
      rxMsg.valid <= 1'b0;
      if (go) begin
        held <= req;
        cnt <= gap;
        pend <= 1'b1;
      end else if (pend && cnt == 4'h0) begin
        rxMsg <= held;
        pend <= 1'b0;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
